// ---- design/dbs_sram_map.vh ----
// Constants for the burst-of-four double-data-rate SRAM port
`ifndef DBS_SRAM_MAP_VH
`define DBS_SRAM_MAP_VH
`define DBS_DATA_W    18
`define DBS_LANES     2
`define DBS_LANE_W    9
`define DBS_ADDR_W    8
`define DBS_DEPTH     256
`define DBS_BURST_LEN 4
`define DBS_IDX_W     2
`define DBS_IDX_ZERO  2'h0
`define DBS_IDX_ONE   2'h1
`define DBS_IDX_MID   2'h2
`define DBS_IDX_LAST  2'h3
`define DBS_CNT_W     3
`define DBS_CNT_ZERO  3'h0
`define DBS_CNT_ONE   3'h1
`define DBS_CNT_DONE  3'h4
`define DBS_LOW_RST   1'h0
`define DBS_HIGH_RST  1'h1
`endif

// ---- design/dbs_sram_port.v ----
// Burst-of-four double-data-rate SRAM port with echo clocks, sampled on the reference clock
`include "dbs_sram_map.vh"

// Functional notes
// - Each read or write moves exactly four words over two clock periods.
// - Address and control are sampled only on primary input clock rising edges.
// - Write data is captured on rising edges of both input clocks.
// - The two lowest address bits choose the burst's starting word.
// - Address is ignored on deselect cycles and at the edge after an accepted load.
// - With load strobe low, select high means read, low means write.
// - Load strobe and direction are ignored at the edge after an accepted load.
// - Low byte select stores its lane; high leaves memory unchanged.
// - Byte selects are sampled separately at each data edge of a write.
// - Two byte selects serve this eighteen-bit variant.
// - Data bus is eighteen two-way lines numbered upward from zero.
// - Read words one and three follow complement output clock, two and four the true one.
// - With both output clocks held high, read data follows the input clock pair.
// - Echo clocks run continuously, following their reference clocks, even when bus is idle.
module dbs_sram_port (
  input  wire                     ref_clk_in,
  input  wire                     rst_n_in,
  input  wire                     k_clk_in,
  input  wire                     k_clk_n_in,
  input  wire                     c_clk_in,
  input  wire                     c_clk_n_in,
  input  wire                     load_strobe_n_in,
  input  wire                     read_write_sel_in,
  input  wire [`DBS_ADDR_W-1:0]   addr_in,
  input  wire [`DBS_LANES-1:0]    byte_write_sel_n_in,
  input  wire [`DBS_DATA_W-1:0]   data_io_in,
  output reg  [`DBS_DATA_W-1:0]   data_io_out,
  output reg                      data_io_oe_n_out,
  output reg  [1:0]               echo_clock_pair_out
);

  localparam ST_IDLE = 2'b01;
  localparam ST_BUSY = 2'b10;

  // Two-stage synchronisers; only stage two is read by logic
  reg [1:0]             k_sync_r;
  reg [1:0]             kn_sync_r;
  reg [1:0]             c_sync_r;
  reg [1:0]             cn_sync_r;
  reg [1:0]             ld_sync_r;
  reg [1:0]             rw_sync_r;
  reg [`DBS_ADDR_W-1:0] addr_s1_r;
  reg [`DBS_ADDR_W-1:0] addr_s2_r;
  reg [`DBS_LANES-1:0]  bws_s1_r;
  reg [`DBS_LANES-1:0]  bws_s2_r;
  reg [`DBS_DATA_W-1:0] data_s1_r;
  reg [`DBS_DATA_W-1:0] data_s2_r;

  reg                   k_prev_r;
  reg                   kn_prev_r;
  reg                   c_prev_r;
  reg                   cn_prev_r;

  reg                   ign_r;
  reg                   pend_v_r;
  reg                   pend_rd_r;
  reg [`DBS_ADDR_W-1:0] pend_addr_r;

  reg [1:0]             st_r;
  reg [1:0]             st_nxt;
  reg [`DBS_IDX_W-1:0]  beat_r;
  reg [`DBS_IDX_W-1:0]  beat_nxt;
  reg                   b_rd_r;
  reg [`DBS_ADDR_W-1:0] b_addr_r;

  reg                   single_r;
  reg                   out_act_r;
  reg [`DBS_CNT_W-1:0]  out_cnt_r;
  reg [`DBS_DATA_W-1:0] rd_buf_r [0:`DBS_BURST_LEN-1];
  reg [`DBS_DATA_W-1:0] mem_r [0:`DBS_DEPTH-1];

  integer               i;

  // Word address within the aligned group of four
  function [`DBS_ADDR_W-1:0] wrap_addr;
    input [`DBS_ADDR_W-1:0] base;
    input [`DBS_IDX_W-1:0]  idx;
    begin
      wrap_addr = {base[`DBS_ADDR_W-1:`DBS_IDX_W], base[`DBS_IDX_W-1:0] + idx};
    end
  endfunction

  wire k_rise  = k_sync_r[1] & ~k_prev_r;
  wire kn_rise = kn_sync_r[1] & ~kn_prev_r;
  wire c_rise  = c_sync_r[1] & ~c_prev_r;
  wire cn_rise = cn_sync_r[1] & ~cn_prev_r;

  wire accept  = k_rise & ~ld_sync_r[1] & ~ign_r;
  wire start   = k_rise & pend_v_r;
  wire busy    = (st_r == ST_BUSY);
  wire odd_ev  = kn_rise & busy & beat_r[0];
  wire mid_ev  = k_rise & busy & (beat_r == `DBS_IDX_MID);
  wire wr_rd   = start ? pend_rd_r : b_rd_r;
  wire wr_now  = (start | odd_ev | mid_ev) & ~wr_rd;
  wire [`DBS_IDX_W-1:0]  wr_idx  = start ? `DBS_IDX_ZERO : beat_r;
  wire [`DBS_ADDR_W-1:0] wr_base = start ? pend_addr_r : b_addr_r;
  wire [`DBS_ADDR_W-1:0] wr_addr = wrap_addr(wr_base, wr_idx);

  wire fe_rise = single_r ? kn_rise : cn_rise;
  wire se_rise = single_r ? k_rise : c_rise;
  wire out_ev  = out_act_r & (out_cnt_r[0] ? se_rise : fe_rise);

  // Output clocks both high selects the input pair as timing reference
  wire both_out_high = c_sync_r[1] & cn_sync_r[1];

  // Per-lane store enables, one for each write select
  genvar g;
  wire [`DBS_LANES-1:0] lane_sel;
  generate
    for (g = 0; g < `DBS_LANES; g = g + 1) begin : g_lane
      assign lane_sel[g] = ~bws_s2_r[g];
    end
  endgenerate

  // Clock and control pins: two flops each
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      k_sync_r  <= {2{`DBS_LOW_RST}};
      kn_sync_r <= {2{`DBS_LOW_RST}};
      c_sync_r  <= {2{`DBS_LOW_RST}};
      cn_sync_r <= {2{`DBS_LOW_RST}};
      ld_sync_r <= {2{`DBS_HIGH_RST}};
      rw_sync_r <= {2{`DBS_LOW_RST}};
    end else begin
      k_sync_r  <= {k_sync_r[0], k_clk_in};
      kn_sync_r <= {kn_sync_r[0], k_clk_n_in};
      c_sync_r  <= {c_sync_r[0], c_clk_in};
      cn_sync_r <= {cn_sync_r[0], c_clk_n_in};
      ld_sync_r <= {ld_sync_r[0], load_strobe_n_in};
      rw_sync_r <= {rw_sync_r[0], read_write_sel_in};
    end
  end

  // Address, lane selects and write data: same delay as the clocks they go with
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_s1_r <= {`DBS_ADDR_W{`DBS_LOW_RST}};
      addr_s2_r <= {`DBS_ADDR_W{`DBS_LOW_RST}};
      bws_s1_r  <= {`DBS_LANES{`DBS_HIGH_RST}};
      bws_s2_r  <= {`DBS_LANES{`DBS_HIGH_RST}};
      data_s1_r <= {`DBS_DATA_W{`DBS_LOW_RST}};
      data_s2_r <= {`DBS_DATA_W{`DBS_LOW_RST}};
    end else begin
      addr_s1_r <= addr_in;
      addr_s2_r <= addr_s1_r;
      bws_s1_r  <= byte_write_sel_n_in;
      bws_s2_r  <= bws_s1_r;
      data_s1_r <= data_io_in;
      data_s2_r <= data_s1_r;
    end
  end

  // Previous synchronised clock levels, for rising-edge detection
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      k_prev_r  <= `DBS_LOW_RST;
      kn_prev_r <= `DBS_LOW_RST;
      c_prev_r  <= `DBS_LOW_RST;
      cn_prev_r <= `DBS_LOW_RST;
    end else begin
      k_prev_r  <= k_sync_r[1];
      kn_prev_r <= kn_sync_r[1];
      c_prev_r  <= c_sync_r[1];
      cn_prev_r <= cn_sync_r[1];
    end
  end

  // Command capture: one accepted load, then one ignored edge
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ign_r       <= `DBS_LOW_RST;
      pend_v_r    <= `DBS_LOW_RST;
      pend_rd_r   <= `DBS_LOW_RST;
      pend_addr_r <= {`DBS_ADDR_W{`DBS_LOW_RST}};
    end else if (k_rise) begin
      ign_r    <= accept;
      pend_v_r <= accept;
      if (accept) begin
        pend_rd_r   <= rw_sync_r[1];
        pend_addr_r <= addr_s2_r;
      end
    end
  end

  // Timing reference choice, changed only at K edges so no half period mixes sources
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      single_r <= `DBS_LOW_RST;
    end else if (k_rise) begin
      single_r <= both_out_high;
    end
  end

  // Burst sequencer: word 0 at K, 1 at K#, 2 at next K, 3 at next K#
  always @* begin
    st_nxt   = st_r;
    beat_nxt = beat_r;
    case (st_r)
      ST_IDLE: begin
        if (start) begin
          st_nxt   = ST_BUSY;
          beat_nxt = `DBS_IDX_ONE;
        end
      end
      ST_BUSY: begin
        if (odd_ev || mid_ev) begin
          beat_nxt = beat_r + `DBS_IDX_ONE;
          if (beat_r == `DBS_IDX_LAST) begin
            st_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        st_nxt   = ST_IDLE;
        beat_nxt = `DBS_IDX_ZERO;
      end
    endcase
  end

  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r     <= ST_IDLE;
      beat_r   <= `DBS_IDX_ZERO;
    end else begin
      st_r   <= st_nxt;
      beat_r <= beat_nxt;
    end
  end

  // Burst context: direction and start address latched once per burst
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      b_rd_r   <= `DBS_LOW_RST;
      b_addr_r <= {`DBS_ADDR_W{`DBS_LOW_RST}};
    end else if (start) begin
      b_rd_r   <= pend_rd_r;
      b_addr_r <= pend_addr_r;
    end
  end

  // Byte lanes stored only where their select is low at this data edge
  always @(posedge ref_clk_in) begin
    if (wr_now) begin
      for (i = 0; i < `DBS_LANES; i = i + 1) begin
        if (lane_sel[i]) begin
          mem_r[wr_addr][i*`DBS_LANE_W +: `DBS_LANE_W] <= data_s2_r[i*`DBS_LANE_W +: `DBS_LANE_W];
        end
      end
    end
  end

  // Read path: snapshot four words, drive them on the timing reference edges
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_act_r        <= `DBS_LOW_RST;
      out_cnt_r        <= `DBS_CNT_ZERO;
      data_io_out      <= {`DBS_DATA_W{`DBS_LOW_RST}};
      data_io_oe_n_out <= `DBS_HIGH_RST;
      for (i = 0; i < `DBS_BURST_LEN; i = i + 1) begin
        rd_buf_r[i] <= {`DBS_DATA_W{`DBS_LOW_RST}};
      end
    end else begin
      if (out_ev) begin
        if (out_cnt_r == `DBS_CNT_DONE) begin
          out_act_r        <= `DBS_LOW_RST;
          data_io_oe_n_out <= `DBS_HIGH_RST;
        end else begin
          data_io_out      <= rd_buf_r[out_cnt_r[`DBS_IDX_W-1:0]];
          data_io_oe_n_out <= `DBS_LOW_RST;
          out_cnt_r        <= out_cnt_r + `DBS_CNT_ONE;
        end
      end
      // A new read restarts the count, winning over the step that drives the previous word three in the same cycle
      if (start && pend_rd_r) begin
        out_act_r <= `DBS_HIGH_RST;
        out_cnt_r <= `DBS_CNT_ZERO;
        for (i = 0; i < `DBS_BURST_LEN; i = i + 1) begin
          rd_buf_r[i] <= mem_r[wrap_addr(pend_addr_r, i[`DBS_IDX_W-1:0])];
        end
      end
    end
  end

  // Echo clocks mirror the timing reference in use
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      echo_clock_pair_out <= {2{`DBS_LOW_RST}};
    end else if (single_r) begin
      echo_clock_pair_out <= {k_sync_r[1], kn_sync_r[1]};
    end else begin
      echo_clock_pair_out <= {c_sync_r[1], cn_sync_r[1]};
    end
  end

endmodule

// ---- tb/dbs_port_monitor.sv ----
// Concurrent checks on the burst SRAM port outputs
`include "dbs_sram_map.vh"
module dbs_port_monitor (
  input wire                   ref_clk_in,
  input wire                   rst_n_in,
  input wire                   k_clk_in,
  input wire                   c_clk_in,
  input wire                   c_clk_n_in,
  input wire                   load_strobe_n_in,
  input wire                   read_write_sel_in,
  input wire [`DBS_DATA_W-1:0] data_io_out,
  input wire                   data_io_oe_n_out,
  input wire [1:0]             echo_clock_pair_out
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [6:0] low_cnt_r;
  // Length of the current stretch of driven read data
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) low_cnt_r <= 7'h00;
    else low_cnt_r <= data_io_oe_n_out ? 7'h00 : low_cnt_r + 7'h01;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_load;
    $rose(k_clk_in) && !load_strobe_n_in && $past(load_strobe_n_in, 8);
  endsequence
  sequence s_read_load;
    s_load ##0 (read_write_sel_in && data_io_oe_n_out);
  endsequence
  sequence s_write_load;
    s_load ##0 !read_write_sel_in;
  endsequence
  a_read_starts: assert property (s_read_load |-> ##[12:20] !data_io_oe_n_out)
    else $error("read burst did not start");
  a_burst_len: assert property ($rose(data_io_oe_n_out) |-> low_cnt_r[3:0] == 4'h0 && low_cnt_r != 7'h00)
    else $error("read burst not four words long");
  a_word_hold: assert property (!data_io_oe_n_out && $changed(data_io_out) |=> $stable(data_io_out) [*3])
    else $error("read word changed early");
  a_ignore_next: assert property (s_write_load |-> ##28 data_io_oe_n_out)
    else $error("load after accepted load was obeyed");
  a_echo_true: assert property ($rose(echo_clock_pair_out[1]) |-> $past(c_clk_in, 3))
    else $error("true echo rose without its clock");
  a_echo_comp: assert property ($rose(echo_clock_pair_out[0]) |-> $past(c_clk_n_in, 3))
    else $error("complement echo rose without its clock");
  a_echo_runs: assert property ($rose(c_clk_in) |-> ##[2:5] echo_clock_pair_out[1])
    else $error("true echo did not follow");
  a_echo_stops: assert property ($fell(c_clk_n_in) |-> ##[2:5] !echo_clock_pair_out[0])
    else $error("complement echo did not fall");
endmodule
bind dbs_sram_port dbs_port_monitor u_mon (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .k_clk_in(k_clk_in),
  .c_clk_in(c_clk_in), .c_clk_n_in(c_clk_n_in), .load_strobe_n_in(load_strobe_n_in),
  .read_write_sel_in(read_write_sel_in), .data_io_out(data_io_out), .data_io_oe_n_out(data_io_oe_n_out),
  .echo_clock_pair_out(echo_clock_pair_out));

// ---- tb/dbs_ctrl_model.sv ----
// Far-side controller model: input and output clock pairs
module dbs_ctrl_model (
  input  wire single_in,
  output reg  k_out,
  output reg  k_n_out,
  output reg  c_out,
  output reg  c_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    k_out = 1'b0;
    k_n_out = 1'b1;
    #13;
    forever begin
      #160;
      k_out = ~k_out;
      k_n_out = ~k_n_out;
    end
  end
  // Output pair follows the input pair, or both sit high in single-clock mode
  always @* begin
    c_out = single_in | k_out;
    c_n_out = single_in | k_n_out;
  end
endmodule

// ---- tb/tb_ddr_burst4_sram_port.sv ----
// Self-checking bench for the burst SRAM port
`include "dbs_sram_map.vh"
module tb_ddr_burst4_sram_port;
  timeunit 1ns;
  timeprecision 1ps;
  reg                   clk, rst_n, single, ld_n, rw;
  reg  [7:0]            addr;
  reg  [1:0]            bw_n;
  reg  [`DBS_DATA_W-1:0] din;
  reg  [`DBS_DATA_W-1:0] mem [0:255];
  wire [`DBS_DATA_W-1:0] dout;
  wire                  oe_n, k, k_n, c, c_n;
  wire [1:0]            echo;
  integer               fails, checks_done;
  dbs_ctrl_model PM (.single_in(single), .k_out(k), .k_n_out(k_n), .c_out(c), .c_n_out(c_n));
  dbs_sram_port DUT (.ref_clk_in(clk), .rst_n_in(rst_n), .k_clk_in(k), .k_clk_n_in(k_n), .c_clk_in(c),
    .c_clk_n_in(c_n), .load_strobe_n_in(ld_n), .read_write_sel_in(rw), .addr_in(addr),
    .byte_write_sel_n_in(bw_n), .data_io_in(din), .data_io_out(dout), .data_io_oe_n_out(oe_n),
    .echo_clock_pair_out(echo));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input [17:0] got, input [17:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Inputs move two block cycles after a clock edge, clear of the next edge
  task automatic edge_wait(input bit comp);
    if (comp) @(posedge k_n);
    else @(posedge k);
    repeat (2) @(negedge clk);
  endtask
  task automatic wr(input [7:0] a, input [71:0] d, input [7:0] b, input bit ghost);
    integer j;
    reg [7:0] wa;
    edge_wait(1'b0);
    ld_n = 1'b0;
    rw = 1'b0;
    addr = a;
    edge_wait(1'b0);
    ld_n = !ghost;
    rw = 1'b1;
    addr = ~a;
    for (j = 0; j < 4; j = j + 1) begin
      if (j > 0) begin
        edge_wait(!j[0]);
        ld_n = 1'b1;
      end
      din = d[18*j +: 18];
      bw_n = b[2*j +: 2];
      wa = {a[7:2], a[1:0] + j[1:0]};
      if (!b[2*j]) mem[wa][8:0] = d[18*j +: 9];
      if (!b[2*j+1]) mem[wa][17:9] = d[18*j+9 +: 9];
    end
    edge_wait(1'b1);
    din = ~din;
    bw_n = 2'h3;
  endtask
  task automatic rd(input [7:0] a, input integer n);
    integer j, i, t;
    reg [7:0] ra;
    fork
      begin
        edge_wait(1'b0);
        ld_n = 1'b0;
        rw = 1'b1;
        addr = a;
        for (j = 1; j < 2 * n + 1; j = j + 1) begin
          edge_wait(1'b0);
          ld_n = j[0] | (j == 2 * n);
          addr = a + 8'h04;
        end
        addr = ~a;
      end
      begin
        t = 0;
        while (oe_n !== 1'b0 && t < 40) begin
          @(negedge clk);
          t = t + 1;
        end
        for (i = 0; i < 4 * n; i = i + 1) begin
          ra = a + {i[5:2], 2'h0};
          ra[1:0] = a[1:0] + i[1:0];
          chk(dout, mem[ra]);
          repeat (4) @(negedge clk);
        end
        chk({17'h0, oe_n}, 18'h00001);
      end
    join
  endtask
  task automatic t_wrap;
    wr(8'h12, {18'h3FFFF, 18'h2AAAA, 18'h15555, 18'h0F0F0}, 8'h00, 1'b0);
    rd(8'h10, 1);
    $display("wrap test done");
  endtask
  task automatic t_mask;
    wr(8'h17, {18'h11111, 18'h22222, 18'h33333, 18'h04444}, 8'h00, 1'b0);
    wr(8'h10, {18'h3C3C3, 18'h1E1E1, 18'h0F0F0, 18'h2D2D2}, 8'h36, 1'b1);
    rd(8'h10, 2);
    $display("mask test done");
  endtask
  task automatic t_single;
    single = 1'b1;
    rd(8'h12, 1);
    single = 1'b0;
    $display("single clock test done");
  endtask
  initial begin
    fails = 0;
    checks_done = 0;
    {rst_n, single, ld_n, rw, addr, bw_n, din} = {4'h2, 8'h00, 2'h3, 18'h00000};
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_wrap;
    t_mask;
    t_single;
    close_out;
  end
  initial begin
    #100000;
    fails = fails + 1;
    close_out;
  end
endmodule
